// File: hw/fault_pkg.sv
// shared types and constants for the error flag and halt control block
package fault_pkg;

  localparam int unsigned IPTR_W      = 32;
  localparam int unsigned LINK_N      = 4;
  // instruction pointer offsets left behind by each kind of halt
  localparam logic [31:0] ERR_IP_OFS  = 32'h0000_0002;
  localparam logic [31:0] DBG_IP_OFS  = 32'h0000_0001;
  localparam logic        FLAG_CLR    = 1'b0;
  localparam logic        FLAG_SET    = 1'b1;

  // sources that may raise the error flag, one pulse each
  typedef struct packed {
    logic overflow;
    logic div_zero;
    logic bounds;
    logic soft_set;
    logic fpu;
  } fault_src_t;

  // flag pair saved over a pre-emption
  typedef struct packed {
    logic err;
    logic hof;
  } flag_pair_t;

  // per-link activity seen by the halt logic
  typedef struct packed {
    logic [LINK_N-1:0] in_busy;
    logic [LINK_N-1:0] out_busy;
  } link_stat_t;

  typedef enum logic [1:0] {
    RUN,
    DBG_WAIT,
    HALT_ERR,
    HALT_DBG
  } run_state_t;

endpackage

// File: hw/flag_save.sv
// save and restore of the flag pair around a high priority pre-emption
`timescale 1ns/1ps
module flag_save
  import fault_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_preempt,
  input  wire logic       i_hi_done,
  input  wire flag_pair_t i_live,
  output flag_pair_t      o_saved,
  output logic            o_active
);

  // capture the low priority flags on entry, hold until the high priority ends
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_saved  <= '0;
      o_active <= 1'b0;
    end else if (i_preempt && !o_active) begin
      o_saved  <= i_live;
      o_active <= 1'b1;
    end else if (i_hi_done && o_active) begin
      o_active <= 1'b0;
    end
  end

endmodule

// File: hw/link_quiesce.sv
// link gating and idle detection while the processor is halted
`timescale 1ns/1ps
module link_quiesce
  import fault_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_reset,
  input  wire logic       i_halted,
  input  wire logic       i_dbg_req,
  input  wire link_stat_t i_links,
  output logic            o_out_fetch_ok,
  output logic            o_links_idle
);

  logic [LINK_N-1:0] busy;

  // a link counts busy while either direction still has a transfer
  genvar g;
  generate
    for (g = 0; g < LINK_N; g++) begin : g_link
      assign busy[g] = i_links.in_busy[g] | i_links.out_busy[g];
    end
  endgenerate

  // output links stop fetching from memory once halted or under debug request
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_out_fetch_ok <= 1'b1;
    end else begin
      o_out_fetch_ok <= !(i_halted || i_dbg_req);
    end
  end

  // idle only after every outstanding transfer has finished
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_links_idle <= 1'b0;
    end else begin
      o_links_idle <= i_halted && (busy == '0);
    end
  end

endmodule

// File: hw/error_flag_halt_control.sv
// error flag, halt on fault and halt state control for the processor core
`timescale 1ns/1ps
module error_flag_halt_control
  import fault_pkg::*;
(
  input  wire logic              i_core_clk,
  input  wire logic              i_reset,
  input  wire fault_src_t        i_fault,
  input  wire logic              i_test_clear,
  input  wire logic              i_hof_set,
  input  wire logic              i_hof_clear,
  input  wire logic              i_preempt,
  input  wire logic              i_hi_done,
  input  wire logic              i_dbg_halt_req,
  input  wire logic              i_desched,
  input  wire logic [IPTR_W-1:0] i_iptr,
  input  wire logic              i_refresh_due,
  input  wire link_stat_t        i_links,
  output logic                   o_error_status_pin,
  output logic                   o_halt_on_fault_flag,
  output logic                   o_test_result,
  output logic                   o_halted,
  output logic [IPTR_W-1:0]      o_stack_a,
  output logic                   o_stack_a_valid,
  output logic                   o_refresh_go,
  output logic                   o_out_fetch_ok,
  output logic                   o_links_idle
);

  //////////////////////////////////////////////////////////////////////////////
  // local signals

  logic        err_r;
  logic        err_nxt;
  logic        hof_r;
  logic        hof_nxt;
  logic        any_fault;
  logic        err_rise;
  run_state_t  state_r;
  run_state_t  state_nxt;
  flag_pair_t  live;
  flag_pair_t  saved;
  logic        save_active;
  logic        preempt_go;
  logic        hi_end;
  logic        dbg_halt;

  assign any_fault  = |i_fault;
  assign live       = '{err: err_r, hof: hof_r};
  assign preempt_go = i_preempt && !save_active;
  assign hi_end     = i_hi_done && save_active;
  assign dbg_halt   = (state_nxt == HALT_DBG);

  //////////////////////////////////////////////////////////////////////////////
  // error flag next value

  // restore wins over everything; a new fault wins over a clear
  always_comb begin
    err_nxt = err_r;
    if (hi_end) begin
      err_nxt = saved.err;
    end else if (any_fault) begin
      err_nxt = FLAG_SET;
    end else if (i_test_clear) begin
      err_nxt = FLAG_CLR;
    end
  end

  // the flag keeps its value through reset so analysis can find the culprit
  always_ff @(posedge i_core_clk) begin
    err_r <= err_nxt;
  end

  assign err_rise = err_nxt && !err_r;

  //////////////////////////////////////////////////////////////////////////////
  // halt on fault flag

  // cleared on entry to high priority, restored at its end
  always_comb begin
    hof_nxt = hof_r;
    if (hi_end) begin
      hof_nxt = saved.hof;
    end else if (preempt_go) begin
      hof_nxt = FLAG_CLR;
    end else if (i_hof_set) begin
      hof_nxt = FLAG_SET;
    end else if (i_hof_clear) begin
      hof_nxt = FLAG_CLR;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      hof_r <= FLAG_CLR;
    end else begin
      hof_r <= hof_nxt;
    end
  end

  flag_save u_flag_save (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_preempt  (i_preempt),
    .i_hi_done  (i_hi_done),
    .i_live     (live),
    .o_saved    (saved),
    .o_active   (save_active)
  );

  //////////////////////////////////////////////////////////////////////////////
  // run and halt state

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RUN: begin
        if (err_rise && hof_r) begin
          state_nxt = HALT_ERR;
        end else if (i_dbg_halt_req) begin
          state_nxt = i_desched ? HALT_DBG : DBG_WAIT;
        end
      end
      DBG_WAIT: begin
        if (err_rise && hof_r) begin
          state_nxt = HALT_ERR;
        end else if (i_desched) begin
          state_nxt = HALT_DBG;
        end
      end
      HALT_ERR: begin
        state_nxt = HALT_ERR;
      end
      default: begin
        state_nxt = HALT_DBG;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state_r <= RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // instruction pointer capture into the first stack register

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_stack_a       <= '0;
      o_stack_a_valid <= 1'b0;
    end else if (state_r != HALT_ERR && state_r != HALT_DBG) begin
      if (state_nxt == HALT_ERR) begin
        o_stack_a       <= i_iptr + ERR_IP_OFS;
        o_stack_a_valid <= 1'b1;
      end else if (dbg_halt) begin
        o_stack_a       <= i_iptr + DBG_IP_OFS;
        o_stack_a_valid <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs

  // pin mirrors the flag except during reset, which drives it low; undefined before first reset is the watcher's problem
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_error_status_pin <= 1'b0;
    end else begin
      o_error_status_pin <= err_nxt;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_halt_on_fault_flag <= FLAG_CLR;
      o_test_result        <= 1'b0;
      o_halted             <= 1'b0;
      o_refresh_go         <= 1'b0;
    end else begin
      o_halt_on_fault_flag <= hof_nxt;
      o_test_result        <= i_test_clear ? !err_r : o_test_result;
      o_halted             <= (state_nxt == HALT_ERR) || (state_nxt == HALT_DBG);
      o_refresh_go         <= i_refresh_due;
    end
  end

  link_quiesce u_link_quiesce (
    .i_core_clk     (i_core_clk),
    .i_reset        (i_reset),
    .i_halted       (o_halted),
    .i_dbg_req      (i_dbg_halt_req),
    .i_links        (i_links),
    .o_out_fetch_ok (o_out_fetch_ok),
    .o_links_idle   (o_links_idle)
  );

endmodule

// File: verification/error_flag_halt_control_checker.sv
// port assertions for the error flag and halt control block
`timescale 1ns/1ps
module efhc_checker
  import fault_pkg::*;
(
  input wire logic              i_core_clk,
  input wire logic              i_reset,
  input wire fault_src_t        i_fault,
  input wire logic              i_test_clear,
  input wire logic              i_preempt,
  input wire logic              i_hi_done,
  input wire logic              i_dbg_halt_req,
  input wire logic              i_desched,
  input wire logic [IPTR_W-1:0] i_iptr,
  input wire logic              i_refresh_due,
  input wire logic              o_error_status_pin,
  input wire logic              o_halt_on_fault_flag,
  input wire logic              o_halted,
  input wire logic [IPTR_W-1:0] o_stack_a,
  input wire logic              o_refresh_go,
  input wire logic              o_out_fetch_ok
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // flag set and clear
  a_fault_sets:
    assert property (|i_fault && !i_hi_done |=> o_error_status_pin) else $error("flag not set");
  a_clear_only:
    assert property (o_error_status_pin && !i_test_clear && !i_hi_done |=> o_error_status_pin) else $error("flag lost");
  // halt causes
  a_err_halt:
    assert property (!o_error_status_pin && o_halt_on_fault_flag && |i_fault && !i_hi_done && !i_preempt && !o_halted
      |=> o_halted && o_stack_a == $past(i_iptr) + ERR_IP_OFS) else $error("fault halt wrong");
  a_no_late_halt:
    assert property (o_error_status_pin && !o_halted && !i_dbg_halt_req |=> !o_halted) else $error("late halt");
  a_halt_sticks:
    assert property (o_halted |=> o_halted) else $error("halt released");
  a_dbg_halt:
    assert property (i_dbg_halt_req && i_desched && !o_halted && !(|i_fault)
      |=> o_halted && o_stack_a == $past(i_iptr) + DBG_IP_OFS) else $error("debug halt wrong");
  a_no_early:
    assert property (!o_halted && !i_desched && !(|i_fault) && !i_hi_done |=> !o_halted) else $error("early halt");
  // side effects
  a_refresh_pass:
    assert property (1'b1 |=> o_refresh_go == $past(i_refresh_due)) else $error("refresh lost");
  a_fetch_stop:
    assert property (o_halted |=> !o_out_fetch_ok) else $error("fetch while halted");
  a_preempt_hof:
    assert property (i_preempt && !i_hi_done && !(|i_fault) && !i_test_clear
      |=> !o_halt_on_fault_flag && o_error_status_pin == $past(o_error_status_pin)) else $error("preempt flags");
  c_err_halt: cover property ($rose(o_halted) && o_error_status_pin);
  c_dbg_halt: cover property (i_dbg_halt_req && i_desched);
  c_restore: cover property (i_hi_done);
endmodule

bind error_flag_halt_control efhc_checker u_chk (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_fault(i_fault),
  .i_test_clear(i_test_clear), .i_preempt(i_preempt), .i_hi_done(i_hi_done), .i_dbg_halt_req(i_dbg_halt_req),
  .i_desched(i_desched), .i_iptr(i_iptr), .i_refresh_due(i_refresh_due), .o_error_status_pin(o_error_status_pin),
  .o_halt_on_fault_flag(o_halt_on_fault_flag), .o_halted(o_halted), .o_stack_a(o_stack_a),
  .o_refresh_go(o_refresh_go), .o_out_fetch_ok(o_out_fetch_ok));

// File: verification/event_watcher.sv
// supervising event input that counts rises of the error status pin
`timescale 1ns/1ps
module event_watcher (
  input  wire logic i_core_clk,
  input  wire logic i_pin,
  output int        o_events
);
  logic last_r = 1'bx;
  initial o_events = 0;
  // unknown pin level after power up never counts as an event
  always @(posedge i_core_clk) begin
    if (last_r === 1'b0 && i_pin === 1'b1) o_events <= o_events + 1;
    last_r <= i_pin;
  end
endmodule

// File: verification/error_flag_halt_control_tb.sv
// self-checking bench for the error flag and halt control block
`timescale 1ns/1ps
module error_flag_halt_control_tb
  import fault_pkg::*;
;
  logic              i_core_clk = 1'b0;
  logic              i_reset = 1'b1;
  logic              i_test_clear, i_hof_set, i_hof_clear, i_preempt, i_hi_done, i_dbg_halt_req, i_desched;
  logic              i_refresh_due, o_error_status_pin, o_halt_on_fault_flag, o_test_result, o_halted;
  logic              o_stack_a_valid, o_refresh_go, o_out_fetch_ok, o_links_idle;
  logic              hp = 1'b0;
  fault_src_t        i_fault;
  link_stat_t        i_links;
  logic [IPTR_W-1:0] i_iptr, o_stack_a;
  logic [IPTR_W-1:0] exp_q[$];
  int                failures = 0, cmp_count = 0, ncyc = 0, events;

  error_flag_halt_control uut (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_fault(i_fault),
    .i_test_clear(i_test_clear), .i_hof_set(i_hof_set), .i_hof_clear(i_hof_clear), .i_preempt(i_preempt),
    .i_hi_done(i_hi_done), .i_dbg_halt_req(i_dbg_halt_req), .i_desched(i_desched), .i_iptr(i_iptr),
    .i_refresh_due(i_refresh_due), .i_links(i_links), .o_error_status_pin(o_error_status_pin),
    .o_halt_on_fault_flag(o_halt_on_fault_flag), .o_test_result(o_test_result), .o_halted(o_halted),
    .o_stack_a(o_stack_a), .o_stack_a_valid(o_stack_a_valid), .o_refresh_go(o_refresh_go),
    .o_out_fetch_ok(o_out_fetch_ok), .o_links_idle(o_links_idle));
  event_watcher u_watch (.i_core_clk(i_core_clk), .i_pin(o_error_status_pin), .o_events(events));

  always #4 i_core_clk = ~i_core_clk;
  ////////////////////////////////////////////////////////////////
  task chk(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t flag got %b want %b", $time, got, exp);
    end
  endtask
  task chk_ip(input logic [IPTR_W-1:0] got, input logic [IPTR_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t stack got %h want %h", $time, got, exp);
    end
  endtask
  // one cycle per step: pulses drop, pointer and refresh go random
  task tick(input int n);
    repeat (n) begin
      @(negedge i_core_clk);
      if (!i_reset) chk(o_refresh_go, i_refresh_due);
      {i_fault, i_test_clear, i_hof_set, i_hof_clear, i_preempt, i_hi_done, i_desched} = '0;
      i_iptr = $urandom;
      i_refresh_due = $urandom;
    end
  endtask
  task end_sim;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // halt entry pops the oldest expected pointer
  always @(negedge i_core_clk) begin
    if (o_halted === 1'b1 && !hp && exp_q.size() > 0) chk_ip(o_stack_a, exp_q.pop_front());
    hp <= (o_halted === 1'b1);
  end
  always @(posedge i_core_clk) begin
    ncyc++;
    if (ncyc == 1000) begin
      failures++;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h372C));
    {i_fault, i_test_clear, i_hof_set, i_hof_clear, i_preempt, i_hi_done, i_desched, i_dbg_halt_req} = '0;
    {i_refresh_due, i_iptr, i_links} = '0;
    repeat (20) @(negedge i_core_clk);
    i_reset = 1'b0;
    i_test_clear = 1; tick(1); chk(o_error_status_pin, 0);
    for (int i = 0; i < 5; i++) begin
      i_fault = fault_src_t'(5'h01 << i); tick(3); chk(o_error_status_pin, 1);
      i_test_clear = 1; tick(1); chk(o_test_result, 0); chk(o_error_status_pin, 0);
    end
    i_hof_set = 1; tick(1); chk(o_halt_on_fault_flag, 1);
    i_preempt = 1; tick(1); chk(o_halt_on_fault_flag, 0); chk(o_error_status_pin, 0);
    i_fault.overflow = 1; tick(1); chk(o_halted, 0); chk(o_error_status_pin, 1);
    i_hi_done = 1; tick(1); chk(o_error_status_pin, 0); chk(o_halt_on_fault_flag, 1);
    i_hof_clear = 1; i_test_clear = 1; tick(1); chk(o_test_result, 1);
    i_fault.bounds = 1; tick(1);
    i_hof_set = 1; tick(3); chk(o_halted, 0);
    i_test_clear = 1; tick(1);
    i_fault.div_zero = 1; exp_q.push_back(i_iptr + ERR_IP_OFS); i_links = link_stat_t'(8'h81);
    tick(3); chk(o_halted, 1); chk(o_out_fetch_ok, 0); chk(o_links_idle, 0);
    chk(o_stack_a_valid, 1);
    i_links = '0; tick(2); chk(o_links_idle, 1);
    tick(4); chk(o_halted, 1);
    i_reset = 1; tick(3); i_reset = 0; tick(1); chk(o_error_status_pin, 1); chk(o_halted, 0);
    i_dbg_halt_req = 1; tick(4); chk(o_halted, 0); chk(o_out_fetch_ok, 0);
    i_desched = 1; exp_q.push_back(i_iptr + DBG_IP_OFS); tick(2); chk(o_halted, 1);
    chk(events == 9, 1);
    end_sim;
  end
endmodule
